// ==== rbas_pkg.sv ====
// package: access request carriers and reset values for the bit access bank
package rbas_pkg;
    localparam int          REG_W         = 16;
    localparam int          REG_COUNT     = 8;
    localparam int          ADDR_W        = 3;
    // register indices inside the bank
    localparam logic [2:0]  IDX_CTRL      = 3'h0;
    localparam logic [2:0]  IDX_STATUS    = 3'h1;
    localparam logic [2:0]  IDX_EVENT     = 3'h2;
    localparam logic [2:0]  IDX_COUNT     = 3'h3;
    localparam logic [2:0]  IDX_CMD       = 3'h4;
    localparam logic [2:0]  IDX_PERSIST   = 3'h5;
    localparam logic [2:0]  IDX_WONLY     = 3'h6;
    localparam logic [2:0]  IDX_ID        = 3'h7;
    // reset values
    localparam logic [15:0] CTRL_RST      = 16'h0000;
    localparam logic [15:0] EVENT_RST     = 16'h0000;
    localparam logic [15:0] CMD_RST       = 16'h00F0;
    localparam logic [15:0] PERSIST_RST   = 16'h0000;
    localparam logic [15:0] WONLY_RST     = 16'h0000;
    localparam logic [15:0] ID_VALUE      = 16'h5A5A; // arbitrary identity value
    // field positions in the command register
    localparam int          CMD_CLR_LSB   = 0;
    localparam int          CMD_SS_LSB    = 4;
    localparam int          CMD_FIELD_W   = 4;
    // control register bits held through soft reset
    localparam logic [15:0] CTRL_KEEP_MSK = 16'hFF00;
    // cycles a self clearing or self setting bit holds its written state
    localparam int          SELF_HOLD_CYC = 1;

    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [REG_W-1:0]  wdata;
    } rbas_req_t;

    typedef struct packed {
        logic             valid;
        logic [REG_W-1:0] rdata;
    } rbas_rsp_t;
endpackage

// ==== rbas_latch.sv ====
// module: one latched status bit, high or low flavour, released by a register read
`timescale 1ns/1ns
module rbas_latch #(
    parameter bit ACTIVE_HIGH = 1'b1
) (
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic cond,
    input  wire logic rd_release,
    output logic      value
);
    logic held_q;
    logic held_d;
    logic follow_q;
    logic follow_d;
    logic act;

    always_comb begin
        act      = ACTIVE_HIGH ? cond : ~cond;
        // once read with the condition present, the bit tracks the condition until it goes
        follow_d = act && (rd_release || follow_q);
        // a new event in the release cycle is kept; release follows capture of read data
        if (act) begin
            held_d = 1'b1;
        end else if (rd_release || follow_q) begin
            held_d = 1'b0;
        end else begin
            held_d = held_q;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            held_q   <= 1'b0;
            follow_q <= 1'b0;
        end else begin
            held_q   <= held_d;
            follow_q <= follow_d;
        end
    end

    assign value = ACTIVE_HIGH ? held_q : ~held_q;
endmodule

// ==== rbas_counter.sv ====
// module: read to clear event counter that saturates
`timescale 1ns/1ns
module rbas_counter #(
    parameter int WIDTH = 16
) (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic             inc,
    input  wire logic             rd_clear,
    output logic      [WIDTH-1:0] count
);
    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (rd_clear) begin
            cnt_d = inc ? {{(WIDTH-1){1'b0}}, 1'b1} : '0;
        end else if (inc && cnt_q != {WIDTH{1'b1}}) begin
            cnt_d = cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign count = cnt_q;
endmodule

// ==== rbas_bank.sv ====
// module: register bank showing every bit access kind
//
// Contract
// - read only bits return their value and ignore all writes.
// - write only bits take writes; reads give no meaningful data.
// - write one to set: ones set bits, zeros change nothing.
// - write one to clear: ones clear bits, zeros change nothing.
// - any write clears a write any to clear bit; reads show it.
// - read to clear field clears on read; writes do nothing.
// - latch low bit holds a low condition until its register is read.
// - latch high bit holds a high condition until its register is read.
// - self clear bit drops to zero itself; writing zero does nothing.
// - self set bit returns to one itself; writing one does nothing.
// - latched high status stays high until read, even if cause vanished.
// - after read, latched high bit follows its cause.
// - keep on soft reset bits hold their value through soft reset.
// - hot reset persistent fields survive hot and function level reset.
// - read write bits take writes and return current setting.
//
// register map (index: content)
// 0 ctrl: read write, upper byte kept on soft reset
// 1 status: [3:0] latch high, [7:4] latch low, [11:8] live read only
// 2 event: [7:0] set by hardware, one to clear; [15:8] write any to clear
// 3 count: read to clear counter of cnt_inc pulses
// 4 cmd: [3:0] self clear, [7:4] self set, [15:8] write one to set
// 5 persist: read write, kept through hot and function level reset
// 6 wonly: write only, reads zero
// 7 id: read only constant
`timescale 1ns/1ns
module rbas_bank (
    input  wire logic                                 clock,
    input  wire logic                                 reset,
    input  wire logic                                 soft_reset,
    input  wire logic                                 hot_reset,
    input  wire rbas_pkg::rbas_req_t                  req,
    output rbas_pkg::rbas_rsp_t                       rsp,
    input  wire logic                   [3:0]         latch_high_cond,
    input  wire logic                   [3:0]         latch_low_cond,
    input  wire logic                   [3:0]         live_status,
    input  wire logic                   [7:0]         event_set,
    input  wire logic                   [7:0]         write_any_to_clear_set,
    input  wire logic                                 cnt_inc,
    output logic                        [15:0]        ctrl_out,
    output logic                        [15:0]        cmd_out,
    output logic                        [15:0]        persist_out,
    output logic                        [15:0]        wonly_out
);
    localparam int                W         = rbas_pkg::REG_W;
    localparam int                HOLD_W    = $clog2(rbas_pkg::SELF_HOLD_CYC + 1);
    localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(rbas_pkg::SELF_HOLD_CYC - 1);

    logic [W-1:0]        ctrl_q;
    logic [W-1:0]        ctrl_d;
    logic [W-1:0]        event_q;
    logic [W-1:0]        event_d;
    logic [W-1:0]        cmd_q;
    logic [W-1:0]        cmd_d;
    logic [HOLD_W-1:0]   hold_q;
    logic [HOLD_W-1:0]   hold_d;
    logic [W-1:0]        persist_q;
    logic [W-1:0]        persist_d;
    logic [W-1:0]        wonly_q;
    logic [W-1:0]        wonly_d;
    rbas_pkg::rbas_rsp_t rsp_q;
    rbas_pkg::rbas_rsp_t rsp_d;
    logic [3:0]          latch_high_val;
    logic [3:0]          latch_low_val;
    logic [W-1:0]        count_val;
    logic                rd_status;
    logic                rd_count;
    logic                wr_ctrl;
    logic                wr_event;
    logic                wr_cmd;
    logic                wr_persist;
    logic                wr_wonly;
    logic [W-1:0]        status_val;

    assign rd_status  = req.rd && req.addr == rbas_pkg::IDX_STATUS;
    assign rd_count   = req.rd && req.addr == rbas_pkg::IDX_COUNT;
    assign wr_ctrl    = req.wr && req.addr == rbas_pkg::IDX_CTRL;
    assign wr_event   = req.wr && req.addr == rbas_pkg::IDX_EVENT;
    assign wr_cmd     = req.wr && req.addr == rbas_pkg::IDX_CMD;
    assign wr_persist = req.wr && req.addr == rbas_pkg::IDX_PERSIST;
    assign wr_wonly   = req.wr && req.addr == rbas_pkg::IDX_WONLY;

    // latched status bits, one per source
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_latch
            rbas_latch #(.ACTIVE_HIGH(1'b1)) u_high (
                .clock      (clock),
                .reset      (reset),
                .cond       (latch_high_cond[g]),
                .rd_release (rd_status),
                .value      (latch_high_val[g])
            );
            rbas_latch #(.ACTIVE_HIGH(1'b0)) u_low (
                .clock      (clock),
                .reset      (reset),
                .cond       (latch_low_cond[g]),
                .rd_release (rd_status),
                .value      (latch_low_val[g])
            );
        end
    endgenerate

    rbas_counter #(.WIDTH(W)) u_cnt (
        .clock    (clock),
        .reset    (reset),
        .inc      (cnt_inc),
        .rd_clear (rd_count),
        .count    (count_val)
    );

    assign status_val = {4'h0, live_status, latch_low_val, latch_high_val};

    // read path: value taken from state before any clear-on-read takes effect
    always_comb begin
        rsp_d.valid = req.rd;
        rsp_d.rdata = rsp_q.rdata;
        if (req.rd) begin
            case (req.addr)
                rbas_pkg::IDX_CTRL:    rsp_d.rdata = ctrl_q;
                rbas_pkg::IDX_STATUS:  rsp_d.rdata = status_val;
                rbas_pkg::IDX_EVENT:   rsp_d.rdata = event_q;
                rbas_pkg::IDX_COUNT:   rsp_d.rdata = count_val;
                rbas_pkg::IDX_CMD:     rsp_d.rdata = cmd_q;
                rbas_pkg::IDX_PERSIST: rsp_d.rdata = persist_q;
                rbas_pkg::IDX_WONLY:   rsp_d.rdata = '0;
                rbas_pkg::IDX_ID:      rsp_d.rdata = rbas_pkg::ID_VALUE;
                default:               rsp_d.rdata = '0;
            endcase
        end
    end

    // control register, read write with a soft reset keep mask
    always_comb begin
        ctrl_d = ctrl_q;
        if (soft_reset) begin
            ctrl_d = (ctrl_q & rbas_pkg::CTRL_KEEP_MSK)
                   | (rbas_pkg::CTRL_RST & ~rbas_pkg::CTRL_KEEP_MSK);
        end else if (wr_ctrl) begin
            ctrl_d = req.wdata;
        end
    end

    // event register: hardware set wins over software clear
    always_comb begin
        event_d = event_q;
        if (soft_reset || hot_reset) begin
            event_d = rbas_pkg::EVENT_RST;
        end else begin
            if (wr_event) begin
                event_d[7:0]  = event_q[7:0] & ~req.wdata[7:0];
                event_d[15:8] = 8'h00;
            end
            event_d[7:0]  = event_d[7:0] | event_set;
            event_d[15:8] = event_d[15:8] | write_any_to_clear_set;
        end
    end

    // command register: self clear, self set, write one to set
    always_comb begin
        cmd_d = cmd_q;
        if (soft_reset || hot_reset) begin
            cmd_d = rbas_pkg::CMD_RST;
        end else begin
            // self clear bits fall and self set bits rise once the hold count runs out
            if (hold_q == '0) begin
                cmd_d[rbas_pkg::CMD_CLR_LSB +: rbas_pkg::CMD_FIELD_W] = '0;
                cmd_d[rbas_pkg::CMD_SS_LSB +: rbas_pkg::CMD_FIELD_W]  = '1;
            end
            if (wr_cmd) begin
                cmd_d[rbas_pkg::CMD_CLR_LSB +: rbas_pkg::CMD_FIELD_W] =
                    req.wdata[rbas_pkg::CMD_CLR_LSB +: rbas_pkg::CMD_FIELD_W];
                cmd_d[rbas_pkg::CMD_SS_LSB +: rbas_pkg::CMD_FIELD_W] =
                    req.wdata[rbas_pkg::CMD_SS_LSB +: rbas_pkg::CMD_FIELD_W];
                cmd_d[15:8] = cmd_q[15:8] | req.wdata[15:8];
            end
        end
    end

    // hold count: self bits keep their written state for a fixed number of cycles
    always_comb begin
        hold_d = hold_q;
        if (soft_reset || hot_reset) begin
            hold_d = '0;
        end else if (wr_cmd) begin
            hold_d = HOLD_LOAD;
        end else if (hold_q != '0) begin
            hold_d = hold_q - HOLD_W'(1);
        end
    end

    // persistent register ignores soft and hot reset, only power-on reset inits it
    always_comb begin
        persist_d = persist_q;
        if (wr_persist) begin
            persist_d = req.wdata;
        end
    end

    // write only register drives logic but never reads back
    always_comb begin
        wonly_d = wonly_q;
        if (soft_reset || hot_reset) begin
            wonly_d = rbas_pkg::WONLY_RST;
        end else if (wr_wonly) begin
            wonly_d = req.wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            ctrl_q <= rbas_pkg::CTRL_RST;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            event_q <= rbas_pkg::EVENT_RST;
        end else begin
            event_q <= event_d;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            cmd_q <= rbas_pkg::CMD_RST;
        end else begin
            cmd_q <= cmd_d;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            hold_q <= '0;
        end else begin
            hold_q <= hold_d;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            persist_q <= rbas_pkg::PERSIST_RST;
        end else begin
            persist_q <= persist_d;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            wonly_q <= rbas_pkg::WONLY_RST;
        end else begin
            wonly_q <= wonly_d;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rsp_q <= '0;
        end else begin
            rsp_q <= rsp_d;
        end
    end

    assign rsp         = rsp_q;
    assign ctrl_out    = ctrl_q;
    assign cmd_out     = cmd_q;
    assign persist_out = persist_q;
    assign wonly_out   = wonly_q;
endmodule

// ==== rbas_host.sv ====
// station management host model issuing register reads and writes
`timescale 1ns/1ns
module rbas_host (
    input  wire logic           clock,
    output rbas_pkg::rbas_req_t req
);
    initial begin
        req = '0;
    end
    // one strobe cycle held across the sampling edge, then idle
    task automatic access(input logic r, input logic [2:0] a, input logic [15:0] d);
        @(negedge clock);
        req <= '{rd: r, wr: !r, addr: a, wdata: r ? 16'h0000 : d};
        @(negedge clock);
        req <= '0;
    endtask
endmodule

// ==== rbas_bank_chk.sv ====
// assertions on the bit access bank ports
`timescale 1ns/1ns
module rbas_bank_chk (
    input wire logic                clock,
    input wire logic                reset,
    input wire logic                soft_reset,
    input wire logic                hot_reset,
    input wire rbas_pkg::rbas_req_t req,
    input wire rbas_pkg::rbas_rsp_t rsp,
    input wire logic [15:0]         ctrl_out,
    input wire logic [15:0]         cmd_out,
    input wire logic [15:0]         persist_out,
    input wire logic [15:0]         wonly_out
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    wire logic quiet  = !soft_reset && !hot_reset;
    wire logic wr_cmd = req.wr && req.addr == rbas_pkg::IDX_CMD;
    property p_valid; req.rd |=> rsp.valid; endproperty
    a_valid: assert property (p_valid) else $error("no read answer");
    property p_id; req.rd && req.addr == rbas_pkg::IDX_ID |=> rsp.rdata == rbas_pkg::ID_VALUE;
    endproperty
    a_id: assert property (p_id) else $error("id value wrong");
    property p_w1s;
        wr_cmd && quiet |=> cmd_out[15:8] == ($past(cmd_out[15:8]) | $past(req.wdata[15:8]));
    endproperty
    a_w1s: assert property (p_w1s) else $error("set by one wrong");
    property p_cmd_pulse;
        wr_cmd && quiet |=> cmd_out[7:0] == $past(req.wdata[7:0]);
    endproperty
    a_cmd_pulse: assert property (p_cmd_pulse) else $error("self bits not taken");
    property p_clr_drop; cmd_out[3:0] != 4'h0 && !wr_cmd |=> cmd_out[3:0] == 4'h0; endproperty
    a_clr_drop: assert property (p_clr_drop) else $error("self clear stuck");
    property p_ss_back; cmd_out[7:4] != 4'hF && !wr_cmd |=> cmd_out[7:4] == 4'hF; endproperty
    a_ss_back: assert property (p_ss_back) else $error("self set stuck");
    property p_ctrl;
        req.wr && req.addr == rbas_pkg::IDX_CTRL && quiet |=> ctrl_out == $past(req.wdata);
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("ctrl write lost");
    property p_soft;
        soft_reset && !req.wr |=> ctrl_out == ($past(ctrl_out) & rbas_pkg::CTRL_KEEP_MSK);
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset on ctrl wrong");
    property p_persist; (hot_reset || soft_reset) && !req.wr |=> $stable(persist_out); endproperty
    a_persist: assert property (p_persist) else $error("persist changed");
    property p_wonly;
        req.wr && req.addr == rbas_pkg::IDX_WONLY && quiet |=> wonly_out == $past(req.wdata);
    endproperty
    a_wonly: assert property (p_wonly) else $error("write only lost");
    c_status: cover property (req.rd && req.addr == rbas_pkg::IDX_STATUS);
    c_count: cover property (req.rd && req.addr == rbas_pkg::IDX_COUNT);
    c_soft: cover property (soft_reset && hot_reset);
endmodule
bind rbas_bank rbas_bank_chk u_chk (.clock(clock), .reset(reset), .soft_reset(soft_reset),
    .hot_reset(hot_reset), .req(req), .rsp(rsp), .ctrl_out(ctrl_out), .cmd_out(cmd_out),
    .persist_out(persist_out), .wonly_out(wonly_out));

// ==== tb_top.sv ====
// self-checking bench for the bit access bank
`timescale 1ns/1ns
module tb_top;
    logic                clock;
    logic                reset, soft_reset, hot_reset, cnt_inc;
    rbas_pkg::rbas_req_t req;
    rbas_pkg::rbas_rsp_t rsp;
    logic [3:0]          hi_cond, lo_cond, live;
    logic [7:0]          ev, any_set;
    logic [15:0]         ctrl_out, cmd_out, persist_out, wonly_out, d1, d2;
    logic [15:0]         exp_q[$];
    logic [31:0]         seed;
    int                  failures, compares;
    rbas_host host (.clock(clock), .req(req));
    rbas_bank dut (.clock(clock), .reset(reset), .soft_reset(soft_reset), .hot_reset(hot_reset),
        .req(req), .rsp(rsp), .latch_high_cond(hi_cond), .latch_low_cond(lo_cond),
        .live_status(live), .event_set(ev), .write_any_to_clear_set(any_set), .cnt_inc(cnt_inc),
        .ctrl_out(ctrl_out), .cmd_out(cmd_out), .persist_out(persist_out), .wonly_out(wonly_out));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [2:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        host.access(1'b1, a, 16'h0000);
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        host.access(1'b0, a, d);
    endtask
    task automatic pulse(input logic [3:0] h, input logic [3:0] l, input logic [7:0] e,
                         input logic [7:0] w);
        @(negedge clock);
        {hi_cond, lo_cond, ev, any_set, cnt_inc} = {h, l, e, w, 1'b1};
        @(negedge clock);
        {hi_cond, lo_cond, ev, any_set, cnt_inc} = {4'h0, 4'hF, 8'h00, 8'h00, 1'b0};
    endtask
    task automatic tally_and_finish();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic done(input string name);
        int n = 0;
        while (exp_q.size() != 0 && n < 20) begin
            @(negedge clock);
            n++;
        end
        if (exp_q.size() != 0) begin
            failures++;
            tally_and_finish();
        end else
            $display("test %s done", name);
    endtask
    // read answers are paired with the oldest expectation
    always @(negedge clock) begin
        if (rsp.valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                failures++;
                $display("BAD t=%0t got=%h exp=none", $time, rsp.rdata);
            end else
                chk(rsp.rdata, exp_q.pop_front());
        end
    end
    initial begin
        {reset, soft_reset, hot_reset, cnt_inc} = 4'b1000;
        {hi_cond, lo_cond, live, ev, any_set} = {4'h0, 4'hF, 4'hA, 8'h00, 8'h00};
        {seed, failures, compares} = {32'hB1A7, 32'h0, 32'h0};
        repeat (5) @(negedge clock);
        reset = 1'b0;
        seed = xs(seed);
        d1 = seed[15:0];
        seed = xs(seed);
        d2 = seed[31:16];
        wr(rbas_pkg::IDX_CTRL, d1);
        chk(ctrl_out, d1);
        rd(rbas_pkg::IDX_CTRL, d1);
        wr(rbas_pkg::IDX_PERSIST, d2);
        @(negedge clock);
        {soft_reset, hot_reset} = 2'b11;
        @(negedge clock);
        {soft_reset, hot_reset} = 2'b00;
        rd(rbas_pkg::IDX_CTRL, d1 & rbas_pkg::CTRL_KEEP_MSK);
        rd(rbas_pkg::IDX_PERSIST, d2);
        done("resets");
        wr(rbas_pkg::IDX_ID, 16'h0000);
        rd(rbas_pkg::IDX_ID, rbas_pkg::ID_VALUE);
        wr(rbas_pkg::IDX_WONLY, d1);
        chk(wonly_out, d1);
        wr(rbas_pkg::IDX_CMD, 16'h010F);
        wr(rbas_pkg::IDX_CMD, 16'h0000);
        rd(rbas_pkg::IDX_CMD, 16'h01F0);
        done("access kinds");
        pulse(4'h0, 4'hF, 8'h0F, 8'h03);
        pulse(4'h0, 4'hF, 8'h00, 8'h00);
        pulse(4'h0, 4'hF, 8'h00, 8'h00);
        rd(rbas_pkg::IDX_EVENT, 16'h030F);
        wr(rbas_pkg::IDX_EVENT, 16'h0000);
        rd(rbas_pkg::IDX_EVENT, 16'h000F);
        wr(rbas_pkg::IDX_EVENT, 16'h0001);
        rd(rbas_pkg::IDX_EVENT, 16'h000E);
        rd(rbas_pkg::IDX_COUNT, 16'h0003);
        wr(rbas_pkg::IDX_COUNT, 16'h0005);
        rd(rbas_pkg::IDX_COUNT, 16'h0000);
        done("events");
        pulse(4'h5, 4'hE, 8'h00, 8'h00);
        wr(rbas_pkg::IDX_STATUS, 16'hFFFF);
        rd(rbas_pkg::IDX_STATUS, 16'h0AE5);
        rd(rbas_pkg::IDX_STATUS, 16'h0AF0);
        hi_cond = 4'h2;
        rd(rbas_pkg::IDX_STATUS, 16'h0AF2);
        hi_cond = 4'h0;
        rd(rbas_pkg::IDX_STATUS, 16'h0AF0);
        rd(rbas_pkg::IDX_STATUS, 16'h0AF0);
        pulse(4'h8, 4'hF, 8'h00, 8'h00);
        rd(rbas_pkg::IDX_STATUS, 16'h0AF8);
        rd(rbas_pkg::IDX_STATUS, 16'h0AF0);
        done("latches");
        tally_and_finish();
    end
endmodule
